// ### mpc_regs.svh
// Register offsets, field positions, reset values and widths of the checker
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ----------------------------------------------------------------------
// Protection set area: four sets, 0x100 bytes apart
// ----------------------------------------------------------------------
`define MPC_SET_COUNT 4
`define MPC_SET_WORDS 14
`define MPC_DATA_RANGES 4
`define MPC_CODE_RANGES 2
`define MPC_IDX_CODE_BASE 8
`define MPC_IDX_DMODE 4'hc
`define MPC_IDX_CMODE 4'hd
`define MPC_DMODE_MASK 32'h0000_00ff
`define MPC_CMODE_MASK 32'h0000_0003
`define MPC_BOUND_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Control and status registers
// ----------------------------------------------------------------------
`define MPC_OFF_STATUS 12'h400
`define MPC_OFF_MASK 12'h404
`define MPC_OFF_CTRL 12'h408
`define MPC_OFF_VADDR 12'h40c
`define MPC_OFF_VINFO 12'h410
`define MPC_ST_RANGE 0
`define MPC_ST_PAGE 1
`define MPC_ST_VAP 2
`define MPC_ST_WIDTH 3
`define MPC_STATUS_RST 3'h0
`define MPC_MASK_RST 3'h0
`define MPC_CTRL_RANGE_EN 0
`define MPC_CTRL_RST 1'h0

// ----------------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------------
`define MPC_SEG_MSB 31
`define MPC_SEG_LSB 28
`define MPC_SEG_USER0_FIRST 4'he
`define MPC_PAGE_BITS 12

`endif

// ### mpc_pkg.sv
// Types shared by the address translation and protection checker
package mpc_pkg;

  // Access kinds issued by the core
  typedef enum logic [1:0] {
    mpc_acc_read,
    mpc_acc_write,
    mpc_acc_fetch
  } mpc_kind_t;

  // Privilege levels, least privileged first
  typedef enum logic [1:0] {
    mpc_user0,
    mpc_user1,
    mpc_super
  } mpc_priv_t;

  // Outcome of one check
  typedef enum logic [1:0] {
    mpc_trap_none,
    mpc_trap_vap,
    mpc_trap_page,
    mpc_trap_range
  } mpc_trap_t;

  // One access as presented by the core
  typedef struct packed {
    logic [31:0] addr;
    mpc_kind_t kind;
    mpc_priv_t priv;
    logic virt_mode;
    logic [1:0] prs;
  } mpc_req_t;

  // Page table entry fields used for translation and permission
  typedef struct packed {
    logic [19:0] ppn;
    logic page_execute_enable;
    logic page_write_enable;
    logic page_read_enable;
  } mpc_pte_t;

  // Result handed back to the core
  typedef struct packed {
    logic allow;
    mpc_trap_t trap;
    logic [31:0] paddr;
  } mpc_rsp_t;

endpackage

// ### mpc_check.sv
// Address translation and memory protection checker with register slave
//
// Behaviour
// R1: The top four address bits name one of sixteen 256MB segments.
// R2: Upper-half virtual addresses pass unchanged as physical addresses.
// R3: Lower half: unchanged in physical mode, page-translated in virtual mode.
// R4: Direct addresses are range checked for reads, writes and fetches.
// R5: Four protection sets exist and the access's set field (prs) picks one.
// R6: Each set's data part holds four ranges for data accesses.
// R7: Each set's code part holds two ranges checked against fetches.
// R8: Each range has a bound pair; each set has mode words for permissions.
// R9: Page-translated addresses take their permissions from the page entry.
// R10: Fetch, write and read need the page's execute, write and read enable.
// R11: In virtual mode least-privileged upper-half accesses are refused.
// R12: In physical mode least-privileged refusals cover segments 14, 15 only.
// R13: Such a refused access raises the address protection trap.
// R14: Every illegal access is blocked and the core is told to take the trap.
// R15: Each violation is also signalled to the debug unit.
// R16: Each access comes with address, kind, privilege, mode and set.
`timescale 1ns/1ps
`include "mpc_regs.svh"

module mpc_check (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic acc_valid_in,
  input wire mpc_pkg::mpc_req_t acc_req_in,
  input wire mpc_pkg::mpc_pte_t acc_pte_in,
  output logic rsp_valid_out,
  output mpc_pkg::mpc_rsp_t rsp_out,
  output logic dbg_violation_out,
  output logic [31:0] dbg_addr_out,
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // Bus slave: one wait state, then the answer
  // ----------------------------------------------------------------------
  logic ack_q;
  logic [31:0] regs_q [64];
  logic [`MPC_ST_WIDTH-1:0] status_q;
  logic [`MPC_ST_WIDTH-1:0] mask_q;
  logic ctrl_q;
  logic [31:0] vaddr_q;
  logic [7:0] vinfo_q;

  wire bus_req = avs_read_in | avs_write_in;
  wire bus_done = bus_req & ack_q;
  wire [3:0] word_idx = avs_address_in[5:2];
  wire in_set = (avs_address_in[11:10] == 2'h0) &
                (avs_address_in[7:6] == 2'h0) & (word_idx <= `MPC_IDX_CMODE);
  wire [5:0] reg_idx = {avs_address_in[9:8], word_idx};
  wire sel_status = avs_address_in == `MPC_OFF_STATUS;
  wire sel_mask = avs_address_in == `MPC_OFF_MASK;
  wire sel_ctrl = avs_address_in == `MPC_OFF_CTRL;
  wire sel_vaddr = avs_address_in == `MPC_OFF_VADDR;
  wire sel_vinfo = avs_address_in == `MPC_OFF_VINFO;
  wire wr_done = avs_write_in & bus_done;

  // Byte lanes merged into the old word; mode words keep their width
  wire [31:0] be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire [31:0] field_mask = (word_idx == `MPC_IDX_DMODE) ? `MPC_DMODE_MASK :
                           (word_idx == `MPC_IDX_CMODE) ? `MPC_CMODE_MASK :
                           32'hffff_ffff;
  wire [31:0] wr_word = ((regs_q[reg_idx] & ~be_mask) |
                         (avs_writedata_in & be_mask)) & field_mask;
  wire [31:0] wr_low = avs_writedata_in & be_mask;

  // Unmapped addresses read as zero and ignore writes
  wire [31:0] rd_mux =
    in_set ? regs_q[reg_idx] :
    sel_status ? {29'h0, status_q} :
    sel_mask ? {29'h0, mask_q} :
    sel_ctrl ? {31'h0, ctrl_q} :
    sel_vaddr ? vaddr_q :
    sel_vinfo ? {24'h0, vinfo_q} : 32'h0000_0000;

  assign avs_waitrequest_out = bus_req & ~ack_q;

  // Answer flag and read data, captured in the wait cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (avs_read_in & ~ack_q) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // Protection set storage, bounds and modes per set
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= `MPC_BOUND_RST;
      end
    end else if (wr_done & in_set) begin
      regs_q[reg_idx] <= wr_word; // R8
    end
  end

  // Mask and control registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_q <= `MPC_MASK_RST;
      ctrl_q <= `MPC_CTRL_RST;
    end else if (wr_done) begin
      if (sel_mask) begin
        mask_q <= wr_low[`MPC_ST_WIDTH-1:0];
      end
      if (sel_ctrl) begin
        ctrl_q <= wr_low[`MPC_CTRL_RANGE_EN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------------
  wire [31:0] a = acc_req_in.addr;
  wire [3:0] seg = a[`MPC_SEG_MSB:`MPC_SEG_LSB]; // R1
  wire upper = seg[3];
  wire direct = upper | ~acc_req_in.virt_mode; // R2 R3
  wire [31:0] pte_addr = {acc_pte_in.ppn, a[`MPC_PAGE_BITS-1:0]};
  wire [31:0] paddr = direct ? a : pte_addr; // R3
  wire is_read = acc_req_in.kind == mpc_pkg::mpc_acc_read;
  wire is_write = acc_req_in.kind == mpc_pkg::mpc_acc_write;
  wire is_fetch = acc_req_in.kind == mpc_pkg::mpc_acc_fetch;
  wire is_user0 = acc_req_in.priv == mpc_pkg::mpc_user0;

  // ----------------------------------------------------------------------
  // Range protection on the selected set
  // ----------------------------------------------------------------------
  wire [5:0] set_base = {acc_req_in.prs, 4'h0}; // R5
  wire [31:0] dmode = regs_q[set_base | {2'h0, `MPC_IDX_DMODE}];
  wire [31:0] cmode = regs_q[set_base | {2'h0, `MPC_IDX_CMODE}];
  wire [5:0] range_pass;

  // Four data ranges then two code ranges; upper bound is exclusive
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_range
      localparam logic [5:0] LO = 6'(2 * g);
      wire [31:0] lo = regs_q[set_base | LO];
      wire [31:0] hi = regs_q[set_base | (LO + 6'h1)];
      wire hit = (a >= lo) & (a < hi); // R8
      if (g < `MPC_DATA_RANGES) begin : g_data
        assign range_pass[g] = hit & ((is_read & dmode[2*g]) |
                                      (is_write & dmode[2*g+1])); // R6
      end else begin : g_code
        assign range_pass[g] = hit & is_fetch &
                               cmode[g-`MPC_DATA_RANGES]; // R7
      end
    end
  endgenerate

  wire range_bad = direct & ctrl_q & ~(|range_pass); // R4

  // Page permissions replace the ranges for translated addresses
  wire page_ok = (is_fetch & acc_pte_in.page_execute_enable) |
                 (is_write & acc_pte_in.page_write_enable) |
                 (is_read & acc_pte_in.page_read_enable); // R9 R10
  wire page_bad = ~direct & ~page_ok;

  // Least privileged level fenced off the upper segments
  wire vap_bad = is_user0 & (acc_req_in.virt_mode ? upper :
                 (seg >= `MPC_SEG_USER0_FIRST)); // R11 R12 R13

  // Address trap outranks permission faults
  wire mpc_pkg::mpc_trap_t trap =
    vap_bad ? mpc_pkg::mpc_trap_vap :
    page_bad ? mpc_pkg::mpc_trap_page :
    range_bad ? mpc_pkg::mpc_trap_range : mpc_pkg::mpc_trap_none;
  wire bad = trap != mpc_pkg::mpc_trap_none;
  wire [`MPC_ST_WIDTH-1:0] events = {`MPC_ST_WIDTH{acc_valid_in}} &
    {trap == mpc_pkg::mpc_trap_vap, trap == mpc_pkg::mpc_trap_page,
     trap == mpc_pkg::mpc_trap_range};

  // ----------------------------------------------------------------------
  // Result and debug outputs, one cycle after the access
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
      dbg_violation_out <= 1'b0;
      dbg_addr_out <= 32'h0000_0000;
    end else begin
      rsp_valid_out <= acc_valid_in; // R16
      dbg_violation_out <= acc_valid_in & bad; // R15
      if (acc_valid_in) begin
        rsp_out.allow <= ~bad; // R14
        rsp_out.trap <= trap; // R14
        rsp_out.paddr <= bad ? 32'h0000_0000 : paddr; // R14
        dbg_addr_out <= a;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  wire [`MPC_ST_WIDTH-1:0] w1c = (wr_done & sel_status) ?
                                 wr_low[`MPC_ST_WIDTH-1:0] : '0;
  wire [`MPC_ST_WIDTH-1:0] next_status = (status_q & ~w1c) | events;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= `MPC_STATUS_RST;
      vaddr_q <= 32'h0000_0000;
      vinfo_q <= 8'h00;
    end else begin
      status_q <= next_status;
      if (acc_valid_in & bad) begin
        vaddr_q <= a;
        vinfo_q <= {acc_req_in.prs, acc_req_in.priv, acc_req_in.kind, trap};
      end
    end
  end

  assign irq_out = |(status_q & mask_q);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_rsp_timing;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in |=> rsp_valid_out ##1 (rsp_valid_out == $past(acc_valid_in));
  endproperty
  a_rsp_timing: assert property (p_rsp_timing) // R14
    else $error("response not one cycle after access");

  property p_vap_virt;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && is_user0 && a[31]
      |=> rsp_out.trap == mpc_pkg::mpc_trap_vap && !rsp_out.allow;
  endproperty
  a_vap_virt: assert property (p_vap_virt) // R11
    else $error("user0 upper access in virtual mode not trapped");

  property p_vap_phys;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && !acc_req_in.virt_mode && is_user0 && a[31:29] == 3'h7
      |=> rsp_out.trap == mpc_pkg::mpc_trap_vap;
  endproperty
  a_vap_phys: assert property (p_vap_phys) // R12
    else $error("user0 access to segment 14 or 15 not trapped");

  property p_phys_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && !acc_req_in.virt_mode && a[31:29] != 3'h7
      |=> rsp_out.trap != mpc_pkg::mpc_trap_vap;
  endproperty
  a_phys_low: assert property (p_phys_low) // R13
    else $error("address trap below segment 14 in physical mode");

  property p_upper_pass;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && a[31] ##1 rsp_out.allow
      |-> rsp_out.paddr == $past(acc_req_in.addr);
  endproperty
  a_upper_pass: assert property (p_upper_pass) // R2
    else $error("upper half address was altered");

  property p_pte_xlate;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && !a[31] ##1 rsp_out.allow
      |-> rsp_out.paddr == {$past(acc_pte_in.ppn), $past(a[11:0])};
  endproperty
  a_pte_xlate: assert property (p_pte_xlate) // R3
    else $error("lower half virtual address not page translated");

  property p_page_fetch;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && !a[31] && !is_user0 &&
      is_fetch && !acc_pte_in.page_execute_enable
      |=> rsp_out.trap == mpc_pkg::mpc_trap_page;
  endproperty
  a_page_fetch: assert property (p_page_fetch) // R10
    else $error("fetch to non executable page allowed");

  property p_range;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && direct && ctrl_q && !vap_bad && range_pass == 6'h00
      |=> rsp_out.trap == mpc_pkg::mpc_trap_range && dbg_violation_out;
  endproperty
  a_range: assert property (p_range) // R4
    else $error("access outside every granted range not trapped");

  property p_dbg;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    rsp_valid_out && !rsp_out.allow |-> dbg_violation_out &&
      status_q != 3'h0;
  endproperty
  a_dbg: assert property (p_dbg) // R15
    else $error("violation without debug or status indication");

  // A read needs the page's read enable
  property p_page_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && !a[31] && !is_user0 &&
      is_read && !acc_pte_in.page_read_enable
      |=> rsp_out.trap == mpc_pkg::mpc_trap_page;
  endproperty
  a_page_read: assert property (p_page_read) // R10
    else $error("read from non readable page allowed");

  // A write needs the page's write enable
  property p_page_write;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && !a[31] && !is_user0 &&
      is_write && !acc_pte_in.page_write_enable
      |=> rsp_out.trap == mpc_pkg::mpc_trap_page;
  endproperty
  a_page_write: assert property (p_page_write) // R10
    else $error("write to non writable page allowed");

  // Page bits alone decide; the ranges have no say on this path
  property p_page_ok;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && acc_req_in.virt_mode && !a[31] && !is_user0 &&
      is_read && acc_pte_in.page_read_enable
      |=> rsp_out.allow && rsp_out.trap == mpc_pkg::mpc_trap_none;
  endproperty
  a_page_ok: assert property (p_page_ok) // R9
    else $error("permitted page access was refused");

  // With range checking off, direct accesses are only fenced by level
  property p_range_off;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && direct && !ctrl_q && !is_user0
      |=> rsp_out.allow && rsp_out.paddr == $past(acc_req_in.addr);
  endproperty
  a_range_off: assert property (p_range_off) // R4
    else $error("direct access refused with range check off");

  // A blocked access never hands out an address
  property p_blocked;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    rsp_valid_out && !rsp_out.allow |-> rsp_out.paddr == 32'h0000_0000 &&
      rsp_out.trap != mpc_pkg::mpc_trap_none;
  endproperty
  a_blocked: assert property (p_blocked) // R14
    else $error("blocked access still carries an address");

  // Status bits only fall through a write of ones to the status word
  property p_sticky;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !(wr_done && sel_status)
      |=> (status_q & $past(status_q)) == $past(status_q);
  endproperty
  a_sticky: assert property (p_sticky) // R14
    else $error("status bit lost without a clear");

  // Debug sees the virtual address of every access
  property p_dbg_addr;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in |=> dbg_addr_out == $past(acc_req_in.addr);
  endproperty
  a_dbg_addr: assert property (p_dbg_addr) // R15
    else $error("debug address does not follow the access");

  // The violation address register keeps the last offender
  property p_vaddr;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    acc_valid_in && is_user0 && acc_req_in.virt_mode && a[31]
      |=> vaddr_q == $past(acc_req_in.addr);
  endproperty
  a_vaddr: assert property (p_vaddr) // R15
    else $error("violating address not recorded");

endmodule

// ### mpc_core_model.sv
// Core model that issues accesses into the checker
`timescale 1ns/1ps
module mpc_core_model (
  input wire logic sys_clk_in,
  output logic acc_valid_out,
  output mpc_pkg::mpc_req_t acc_req_out,
  output mpc_pkg::mpc_pte_t acc_pte_out
);
  // --------------------
  // Access issue
  // --------------------
  // Quiet lines at time zero
  initial begin
    acc_valid_out = 1'b0;
    acc_req_out = '0;
    acc_pte_out = '0;
  end
  // One access per edge, so back-to-back streams come for free
  task automatic send(input mpc_pkg::mpc_req_t r,
      input mpc_pkg::mpc_pte_t p);
    acc_valid_out <= 1'b1;
    acc_req_out <= r;
    acc_pte_out <= p;
    @(posedge sys_clk_in);
  endtask
  // Idle lines flip so a stale value never looks live
  task automatic idle();
    acc_valid_out <= 1'b0;
    acc_req_out <= mpc_pkg::mpc_req_t'(~acc_req_out);
    acc_pte_out <= mpc_pkg::mpc_pte_t'(~acc_pte_out);
    @(posedge sys_clk_in);
  endtask
endmodule

// ### mpc_check_test.sv
// Self-checking bench for the translation and protection checker
`timescale 1ns/1ps
`include "mpc_regs.svh"
module mpc_check_test;
  // --------------------
  // Signals
  // --------------------
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out, dbg_addr_out, rd, ma;
  logic avs_waitrequest_out, acc_valid_in, rsp_valid_out;
  logic dbg_violation_out, irq_out;
  logic v1 = 1'b0;
  logic rng_en = 1'b0;
  logic [31:0] seed = 32'h2d9d9e8a;
  mpc_pkg::mpc_req_t acc_req_in;
  mpc_pkg::mpc_pte_t acc_pte_in;
  mpc_pkg::mpc_rsp_t rsp_out, me;
  mpc_pkg::mpc_rsp_t exp_q[$];
  logic [31:0] adr_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [31:0] LO = 32'h3000_0000;
  localparam logic [31:0] HI = 32'h3000_1000;

  always #2.5 sys_clk_in = ~sys_clk_in;

  mpc_check u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .acc_valid_in(acc_valid_in), .acc_req_in(acc_req_in),
    .acc_pte_in(acc_pte_in), .rsp_valid_out(rsp_valid_out),
    .rsp_out(rsp_out), .dbg_violation_out(dbg_violation_out),
    .dbg_addr_out(dbg_addr_out), .irq_out(irq_out));
  mpc_core_model u_core (.sys_clk_in(sys_clk_in),
    .acc_valid_out(acc_valid_in), .acc_req_out(acc_req_in),
    .acc_pte_out(acc_pte_in));

  // --------------------
  // Expectations
  // --------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Only set 1 data range 0 and code range 0 are programmed, both LO to HI; other sets have empty bounds
  function automatic mpc_pkg::mpc_rsp_t model(
      input mpc_pkg::mpc_req_t r, input mpc_pkg::mpc_pte_t p,
      input logic en);
    mpc_pkg::mpc_rsp_t e;
    logic dir, ok, hit;
    dir = r.addr[31] | ~r.virt_mode;
    hit = r.prs == 2'h1 && r.addr >= LO && r.addr < HI;
    ok = r.kind == mpc_pkg::mpc_acc_fetch ? p.page_execute_enable :
      r.kind == mpc_pkg::mpc_acc_write ? p.page_write_enable :
      p.page_read_enable;
    e.trap = mpc_pkg::mpc_trap_none;
    if (r.priv == mpc_pkg::mpc_user0 && (r.virt_mode ? r.addr[31] :
        r.addr[31:28] >= 4'he))
      e.trap = mpc_pkg::mpc_trap_vap;
    else if (!dir && !ok)
      e.trap = mpc_pkg::mpc_trap_page;
    else if (dir && en && !hit)
      e.trap = mpc_pkg::mpc_trap_range;
    e.allow = e.trap == mpc_pkg::mpc_trap_none;
    e.paddr = !e.allow ? 32'h0 : dir ? r.addr : {p.ppn, r.addr[11:0]};
    return e;
  endfunction

  // --------------------
  // Compare and bus tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_rsp(input mpc_pkg::mpc_rsp_t ex, got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] rsp expected %h seen %h", ex, got);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do
      @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
      input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic irqchk(input logic ex);
    @(negedge sys_clk_in);
    chk("irq", {31'h0, ex}, {31'h0, irq_out});
  endtask
  task automatic go(input mpc_pkg::mpc_req_t r,
      input mpc_pkg::mpc_pte_t p);
    exp_q.push_back(model(r, p, rng_en));
    adr_q.push_back(r.addr);
    u_core.send(r, p);
  endtask
  // Random stream with idle gaps and a bias into the guarded range
  task automatic rand_run(input int n);
    mpc_pkg::mpc_req_t r;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      r.addr = seed[0] ? {LO[31:12], seed[12:1]} : seed;
      seed = lfsr(seed);
      r.kind = mpc_pkg::mpc_kind_t'(2'(seed % 3));
      r.priv = mpc_pkg::mpc_priv_t'(2'(seed[15:8] % 3));
      r.virt_mode = seed[16];
      r.prs = seed[18:17];
      go(r, mpc_pkg::mpc_pte_t'(seed[31:9]));
      if (seed[3])
        u_core.idle();
    end
    u_core.idle();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------
  // Response monitor and watchdog
  // --------------------
  // Every response is matched in order, and its timing against the strobe
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    v1 <= acc_valid_in === 1'b1;
    if (cyc == 8000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (rst_n_in === 1'b1)
      chk("rsp_valid", {31'h0, v1}, {31'h0, rsp_valid_out});
    if (rsp_valid_out === 1'b1 && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      ma = adr_q.pop_front();
      chk_rsp(me, rsp_out);
      chk("dbg_viol", {31'h0, !me.allow}, {31'h0, dbg_violation_out});
      chk("dbg_addr", ma, dbg_addr_out);
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    mpc_pkg::mpc_req_t r;
    logic [31:0] ca [7];
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rdchk("status", `MPC_OFF_STATUS, 32'h0);
    rdchk("mask", `MPC_OFF_MASK, 32'h0);
    rdchk("ctrl", `MPC_OFF_CTRL, 32'h0);
    rdchk("dmode", 12'h130, 32'h0);
    rdchk("unmapped", 12'h500, 32'h0);
    $display("test reset done");
    r = '{32'h9000_0000, mpc_pkg::mpc_acc_read, mpc_pkg::mpc_user0,
      1'b1, 2'h0};
    go(r, '0);
    r = '{32'h0000_1234, mpc_pkg::mpc_acc_write, mpc_pkg::mpc_super,
      1'b1, 2'h0};
    go(r, '{20'h5a5a5, 1'b1, 1'b0, 1'b1});
    u_core.idle();
    rdchk("status", `MPC_OFF_STATUS, 32'h6);
    rdchk("vaddr", `MPC_OFF_VADDR, 32'h0000_1234);
    // Last offender: set 0, supervisor, write, page trap
    rdchk("vinfo", `MPC_OFF_VINFO, 32'h26);
    irqchk(1'b0);
    bus(1'b1, `MPC_OFF_MASK, 32'h2);
    irqchk(1'b1);
    bus(1'b1, `MPC_OFF_STATUS, 32'h2);
    irqchk(1'b0);
    rdchk("status", `MPC_OFF_STATUS, 32'h4);
    bus(1'b1, `MPC_OFF_STATUS, 32'h4);
    rdchk("status", `MPC_OFF_STATUS, 32'h0);
    rand_run(250);
    $display("test direct_page done");
    bus(1'b1, 12'h100, LO);
    bus(1'b1, 12'h104, HI);
    bus(1'b1, 12'h120, LO);
    bus(1'b1, 12'h124, HI);
    bus(1'b1, 12'h130, 32'hffff_ff03);
    rdchk("dmode", 12'h130, 32'h3);
    bus(1'b1, 12'h134, 32'hffff_fffd);
    rdchk("cmode", 12'h134, 32'h1);
    bus(1'b1, `MPC_OFF_CTRL, 32'h1);
    rng_en = 1'b1;
    // Bounds, wrong set, segments 13 and 14, sent back to back
    ca = '{LO, HI - 32'h4, HI, LO, 32'ha000_0000, 32'hd000_0000,
      32'he000_0000};
    for (int i = 0; i < 7; i++) begin
      r.addr = ca[i];
      r.kind = mpc_pkg::mpc_kind_t'(2'(i % 3));
      r.priv = i >= 5 ? mpc_pkg::mpc_user0 : mpc_pkg::mpc_user1;
      r.virt_mode = 1'b0;
      r.prs = i == 3 ? 2'h0 : 2'h1;
      go(r, '0);
    end
    u_core.idle();
    rand_run(250);
    repeat (3) @(posedge sys_clk_in);
    chk("pending", 32'h0, exp_q.size());
    $display("test range done");
    tally_and_finish();
  end
endmodule
